// *** verilog/ccps_pkg.sv ***
// Shared constants and carriers of the clock select and power save block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave port.
package ccps_pkg;

    // System clock
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          CLK_NS          = 1_000_000_000 / CLK_HZ;

    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_GCS         = 6'h00;
    localparam logic [5:0]  IDX_SPRD_STR    = 6'h0A;
    localparam logic [5:0]  IDX_SPRD_EN     = 6'h0B;
    localparam logic [5:0]  IDX_PSC         = 6'h0D;
    localparam logic [5:0]  IDX_OPC         = 6'h0E;
    localparam logic [5:0]  IDX_DBL         = 6'h0F;
    localparam logic [5:0]  IDX_STATE       = 6'h10;

    // Field positions
    localparam int          GCS_SEL_LSB     = 2;
    localparam int          SPRD_BIT        = 7;
    localparam int          PSC_STC_LSB     = 5;
    localparam int          PSC_SHORT_BIT   = 4;
    localparam int          PSC_SHORTW_BIT  = 3;
    localparam int          PSC_DIV_LSB     = 0;
    localparam int          OPC_CLK_LSB     = 6;
    localparam int          OPC_STAT_LSB    = 4;
    localparam int          OPC_WDT_BIT     = 3;
    localparam int          OPC_BUF_LSB     = 0;

    // Reset values: divide by 8, doubler off, all options off
    localparam logic [2:0]  GCS_SEL_RST     = 3'h0;
    localparam logic [7:0]  REG_RST         = 8'h00;

    // Clock select codes
    localparam logic [2:0]  CSEL_DIV8       = 3'h0;
    localparam logic [2:0]  CSEL_PER_FULL   = 3'h1;
    localparam logic [2:0]  CSEL_FULL       = 3'h2;
    localparam logic [2:0]  CSEL_DIV2       = 3'h3;
    localparam logic [2:0]  CSEL_SLOW       = 3'h4;
    localparam logic [2:0]  CSEL_SLOW_OFF   = 3'h5;
    localparam logic [2:0]  CSEL_DIV4       = 3'h6;
    localparam logic [2:0]  CSEL_DIV6       = 3'h7;

    // Two-bit pin source codes
    localparam logic [1:0]  PIN_SRC_A       = 2'h0;
    localparam logic [1:0]  PIN_SRC_B       = 2'h1;
    localparam logic [1:0]  PIN_LOW         = 2'h2;
    localparam logic [1:0]  PIN_HIGH        = 2'h3;

    // Self-timed chip select nominal widths in ns
    localparam logic [8:0]  STC_NS_100      = 9'd296;
    localparam logic [8:0]  STC_NS_101      = 9'd234;
    localparam logic [8:0]  STC_NS_110      = 9'd171;
    localparam logic [8:0]  STC_NS_111      = 9'd109;

    // Doubler low time: base plus one ns per step above code 0
    localparam logic [4:0]  DBL_BASE_NS     = 5'd5;

    // Watchdog force pulse ends on this many 32 kHz edges
    localparam int          WDT_PULSE_EDGES = 2;

    // Wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ccps_wb_req_type;

    // Processor cycle kinds used by the pin sources
    typedef struct packed {
        logic opcode_fetch;
        logic int_ack;
        logic ext_io;
        logic data_mem;
    } ccps_cycle_type;

endpackage : ccps_pkg

// *** verilog/ccps_sync.sv ***
// Two-flop synchroniser with rising edge detect on the settled level.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ccps_sync
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Asynchronous level in
    input  wire logic async_i,
    // Settled level and its rising edge
    output logic      level_o,
    output logic      rise_o
);
    logic meta;
    logic settled;
    logic last;

    // Only the second flop reads the first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta    <= 1'b0;
            settled <= 1'b0;
            last    <= 1'b0;
        end
        else
        begin
            meta    <= async_i;
            settled <= meta;
            last    <= settled;
        end
    end

    assign level_o = settled;
    assign rise_o  = settled & ~last;
endmodule : ccps_sync
`default_nettype wire

// *** verilog/ccps_div.sv ***
// Programmable tick divider: one tick out per div_i ticks in.
// Assumes div_i is at least one; a divisor of one passes src_i through.
`timescale 1ns/1ps
`default_nettype none
module ccps_div
#(
    parameter int W = 4
)
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Source ticks and divisor
    input  wire logic         src_i,
    input  wire logic [W-1:0] div_i,
    // Divided tick
    output logic              tick_o
);
    logic [W-1:0] cnt;

    // Tick on the last source tick of each group
    assign tick_o = src_i & (cnt >= div_i - W'(1));

    // Count source ticks, restart on each output tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt <= '0;
        else if (tick_o)
            cnt <= '0;
        else if (src_i)
            cnt <= cnt + W'(1);
    end
endmodule : ccps_div
`default_nettype wire

// *** verilog/ccps_top.sv ***
// Clock select, spreader, doubler, power save and pin source control.
// Assumes clk_i is the main oscillator and clk32_i a free 32 kHz pin.
//
// Overview of operation
// - Clock select code sets CPU and peripheral divide of the oscillator.
// - Spreader strength bit 7: zero normal, one strong spreading.
// - Spreader enable bit 7 turns the spectrum spreader on or off.
// - Power-save bits 7:5 pick self-timed chip select width or off in 32 kHz modes.
// - Power-save bit 4 gives short chip selects in divided modes.
// - Power-save bit 3 shortens write chip selects, not at full speed.
// - Divider field 000 uses the undivided 32 kHz clock.
// - Divider codes 100 to 111 divide 32 kHz by 2, 4, 8, 16.
// - Doubler code 0000 keeps the clock doubler off.
// - Doubler codes 1 to 15 give low time of 6 to 20 ns.
// - Output bits 7:6 choose the clock pin source or a fixed level.
// - Output bits 5:4 choose the status pin source or a fixed level.
// - Output bit 3 pulls watchdog pin low one to two 32 kHz cycles.
// - Output bits 1:0 choose buffer enable source; bit 2 ignored.
// - Running from 32 kHz disables the periodic interrupt.
// - Real-time clock and watchdog keep the undivided 32 kHz clock.
// - Spreading is applied before the doubler, on the undoubled clock.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ccps_top
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire ccps_pkg::ccps_wb_req_type wb_req_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o,
    // 32 kHz oscillator pin
    input  wire logic                     clk32_i,
    // Processor cycle kinds and watchdog function
    input  wire ccps_pkg::ccps_cycle_type cycle_i,
    input  wire logic                     watchdog_n_i,
    // Clock enables and timer tick
    output logic                          cpu_tick_o,
    output logic                          per_tick_o,
    output logic                          rtc_tick_o,
    // Oscillator, spreader and doubler controls
    output logic                          main_osc_en_o,
    output logic                          spread_en_o,
    output logic                          spread_strong_o,
    output logic                          doubler_en_o,
    output logic [4:0]                    doubler_low_ns_o,
    // Chip select and interrupt controls
    output logic [8:0]                    self_timed_ns_o,
    output logic                          short_cs_o,
    output logic                          short_cs_write_o,
    output logic                          periodic_irq_en_o,
    // Pins
    output logic                          clk_pin_o,
    output logic                          status_pin_o,
    output logic                          watchdog_output_pin_o,
    output logic                          buffer_enable_n_o
);
    import ccps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registers and bus decode
    ////////////////////////////////////////////////////////////////////
    logic [2:0] clk_sel;
    logic       sprd_strong;
    logic       sprd_on;
    logic [7:0] power_save_control;
    logic [7:0] output_pin_control;
    logic [3:0] doubler_delay;
    logic       wdt_force;
    logic       wdt_done;
    logic [5:0] idx;
    logic       wr_now;
    logic       slow_mode;
    logic [7:0] next_rd;

    assign idx    = wb_req_i.adr[7:2];
    // Write takes effect on the edge at which the master sees ack
    assign wr_now = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we
                  & wb_req_i.sel[0] & wb_ack_o;

    // One-cycle ack, one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    end

    // Clock select field
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clk_sel <= GCS_SEL_RST;
        else if (wr_now && idx == IDX_GCS)
            clk_sel <= wb_req_i.dat[GCS_SEL_LSB +: 3];
    end

    // Spreader bits; reserved bits are not stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sprd_strong <= 1'b0;
            sprd_on     <= 1'b0;
        end
        else if (wr_now)
        begin
            if (idx == IDX_SPRD_STR)
                sprd_strong <= wb_req_i.dat[SPRD_BIT];
            if (idx == IDX_SPRD_EN)
                sprd_on     <= wb_req_i.dat[SPRD_BIT];
        end
    end

    // Power save and doubler registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            power_save_control <= REG_RST;
            doubler_delay      <= REG_RST[3:0];
        end
        else if (wr_now)
        begin
            if (idx == IDX_PSC)
                power_save_control <= wb_req_i.dat[7:0];
            if (idx == IDX_DBL)
                doubler_delay      <= wb_req_i.dat[3:0];
        end
    end

    // Output control; force bit clears itself when its pulse ends
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            output_pin_control <= REG_RST;
            wdt_force          <= 1'b0;
        end
        else
        begin
            if (wr_now && idx == IDX_OPC)
            begin
                output_pin_control <= wb_req_i.dat[7:0];
                wdt_force          <= wb_req_i.dat[OPC_WDT_BIT];
            end
            else if (wdt_done)
                wdt_force <= 1'b0;
        end
    end

    // Read data; reserved bits read as zero
    always_comb
    begin
        next_rd = 8'h00;
        unique case (idx)
            IDX_GCS:      next_rd[GCS_SEL_LSB +: 3] = clk_sel;
            IDX_SPRD_STR: next_rd[SPRD_BIT] = sprd_strong;
            IDX_SPRD_EN:  next_rd[SPRD_BIT] = sprd_on;
            IDX_PSC:      next_rd = power_save_control;
            IDX_OPC:      next_rd = {output_pin_control[7:4], wdt_force,
                                     output_pin_control[2:0]};
            IDX_DBL:      next_rd[3:0] = doubler_delay;
            IDX_STATE:    next_rd = {4'h0, slow_mode, main_osc_en_o,
                                     watchdog_output_pin_o, doubler_en_o};
            default:      next_rd = 8'h00;
        endcase
    end

    // Read data register, zero-extended to the bus
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else
            wb_dat_o <= {24'h00_0000, next_rd};
    end

    ////////////////////////////////////////////////////////////////////
    // Clock division
    ////////////////////////////////////////////////////////////////////
    logic       s32_rise;
    logic [3:0] cpu_div;
    logic [3:0] per_div;
    logic [4:0] slow_div;
    logic       main_cpu_tick;
    logic       main_per_tick;
    logic       slow_tick;

    assign slow_mode = (clk_sel == CSEL_SLOW) || (clk_sel == CSEL_SLOW_OFF);

    // Oscillator divisors per clock select code
    always_comb
    begin
        unique case (clk_sel)
            CSEL_FULL: cpu_div = 4'h1;
            CSEL_DIV2: cpu_div = 4'h2;
            CSEL_DIV4: cpu_div = 4'h4;
            CSEL_DIV6: cpu_div = 4'h6;
            default:   cpu_div = 4'h8;
        endcase
        per_div = (clk_sel == CSEL_PER_FULL) ? 4'h1 : cpu_div;
    end

    // 32 kHz divisor; reserved codes fall back to undivided
    always_comb
    begin
        unique case (power_save_control[PSC_DIV_LSB +: 3])
            3'h4:    slow_div = 5'h02;
            3'h5:    slow_div = 5'h04;
            3'h6:    slow_div = 5'h08;
            3'h7:    slow_div = 5'h10;
            default: slow_div = 5'h01;
        endcase
    end

    ccps_sync u_sync32
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (clk32_i),
        .level_o (),
        .rise_o  (s32_rise)
    );

    ccps_div #(.W(4)) u_div_cpu
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .src_i  (1'b1),
        .div_i  (cpu_div),
        .tick_o (main_cpu_tick)
    );

    ccps_div #(.W(4)) u_div_per
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .src_i  (1'b1),
        .div_i  (per_div),
        .tick_o (main_per_tick)
    );

    ccps_div #(.W(5)) u_div_slow
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .src_i  (s32_rise),
        .div_i  (slow_div),
        .tick_o (slow_tick)
    );

    // Slow modes take both clocks from the 32 kHz chain
    assign cpu_tick_o    = slow_mode ? slow_tick : main_cpu_tick;
    assign per_tick_o    = slow_mode ? slow_tick : main_per_tick;
    assign main_osc_en_o = (clk_sel != CSEL_SLOW_OFF);
    // Timers always see every 32 kHz edge
    assign rtc_tick_o        = s32_rise;
    assign periodic_irq_en_o = ~slow_mode;

    ////////////////////////////////////////////////////////////////////
    // Spreader, doubler and chip select options
    ////////////////////////////////////////////////////////////////////
    // Spreader settings feed the stage ahead of the doubler
    assign spread_en_o      = sprd_on;
    assign spread_strong_o  = sprd_strong;
    assign doubler_en_o     = (doubler_delay != 4'h0);
    assign doubler_low_ns_o = doubler_en_o
                            ? DBL_BASE_NS + {1'b0, doubler_delay}
                            : 5'h00;
    // Short timing never at full speed
    assign short_cs_o       = power_save_control[PSC_SHORT_BIT]
                            & (clk_sel != CSEL_FULL);
    assign short_cs_write_o = power_save_control[PSC_SHORTW_BIT]
                            & (clk_sel != CSEL_FULL);

    // Self-timed width only in the 32 kHz modes
    always_comb
    begin
        self_timed_ns_o = 9'h000;
        if (slow_mode)
        begin
            unique case (power_save_control[PSC_STC_LSB +: 3])
                3'h4:    self_timed_ns_o = STC_NS_100;
                3'h5:    self_timed_ns_o = STC_NS_101;
                3'h6:    self_timed_ns_o = STC_NS_110;
                3'h7:    self_timed_ns_o = STC_NS_111;
                default: self_timed_ns_o = 9'h000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin sources
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {WD_IDLE, WD_EDGE1, WD_EDGE2} ccps_wd_type;
    ccps_wd_type wd_state;
    logic [1:0]  wd_edges;
    logic        per_wave;
    logic        per_half;

    // Peripheral clock waveform and its half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            per_wave <= 1'b0;
            per_half <= 1'b0;
        end
        else if (per_tick_o)
        begin
            per_wave <= ~per_wave;
            if (per_wave)
                per_half <= ~per_half;
        end
    end

    // Watchdog force pulse spans one to two 32 kHz cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wd_state <= WD_IDLE;
            wd_edges <= 2'h0;
        end
        else
        begin
            unique case (wd_state)
                WD_IDLE:
                    if (wdt_force)
                    begin
                        wd_state <= WD_EDGE1;
                        wd_edges <= 2'h0;
                    end
                WD_EDGE1:
                    if (s32_rise)
                    begin
                        wd_edges <= wd_edges + 2'h1;
                        if (wd_edges == 2'(WDT_PULSE_EDGES - 1))
                            wd_state <= WD_EDGE2;
                    end
                WD_EDGE2:
                    wd_state <= WD_IDLE;
                // Unused code falls back to idle
                default:
                    wd_state <= WD_IDLE;
            endcase
        end
    end
    assign wdt_done = (wd_state == WD_EDGE2);

    // Registered pin drivers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_pin_o             <= 1'b0;
            status_pin_o          <= 1'b1;
            watchdog_output_pin_o <= 1'b1;
            buffer_enable_n_o     <= 1'b1;
        end
        else
        begin
            unique case (output_pin_control[OPC_CLK_LSB +: 2])
                PIN_SRC_A: clk_pin_o <= per_wave;
                PIN_SRC_B: clk_pin_o <= per_half;
                PIN_LOW:   clk_pin_o <= 1'b0;
                PIN_HIGH:  clk_pin_o <= 1'b1;
            endcase
            unique case (output_pin_control[OPC_STAT_LSB +: 2])
                PIN_SRC_A: status_pin_o <= ~cycle_i.opcode_fetch;
                PIN_SRC_B: status_pin_o <= ~cycle_i.int_ack;
                PIN_LOW:   status_pin_o <= 1'b0;
                PIN_HIGH:  status_pin_o <= 1'b1;
            endcase
            // Bit 2 takes no part in the choice
            unique case (output_pin_control[OPC_BUF_LSB +: 2])
                PIN_SRC_A: buffer_enable_n_o <= ~cycle_i.ext_io;
                PIN_SRC_B: buffer_enable_n_o <= ~cycle_i.data_mem;
                PIN_LOW:   buffer_enable_n_o <= 1'b0;
                PIN_HIGH:  buffer_enable_n_o <= 1'b1;
            endcase
            watchdog_output_pin_o <= wdt_force ? 1'b0 : watchdog_n_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    full_speed_a: assert property (clk_sel == CSEL_FULL |->
        cpu_tick_o && per_tick_o)
        else $error("full speed clocks not running every cycle");
    osc_stop_a: assert property (!main_osc_en_o |->
        cpu_tick_o == slow_tick)
        else $error("oscillator off but processor not on slow clock");
    strength_wr_a: assert property (wr_now && idx == IDX_SPRD_STR
        |=> spread_strong_o == $past(wb_req_i.dat[7]))
        else $error("spreader strength not taken from write");
    enable_wr_a: assert property (wr_now && idx == IDX_SPRD_EN
        |=> spread_en_o == $past(wb_req_i.dat[7]))
        else $error("spreader enable not taken from write");
    self_timed_a: assert property (self_timed_ns_o != 9'h000 |->
        slow_mode && power_save_control[7])
        else $error("self-timed width outside slow mode");
    short_cs_a: assert property (short_cs_o |->
        clk_sel != CSEL_FULL && power_save_control[4])
        else $error("short chip select at full speed");
    slow_undiv_a: assert property (slow_mode
        && power_save_control[2:0] == 3'h0 && s32_rise |-> cpu_tick_o)
        else $error("undivided 32 kHz tick missed");
    doubler_off_a: assert property (doubler_delay == 4'h0 |->
        !doubler_en_o && doubler_low_ns_o == 5'h00)
        else $error("doubler on with zero delay code");
    clk_low_a: assert property (output_pin_control[7:6] == 2'h2
        |=> !clk_pin_o)
        else $error("clock pin not held low");
    wdt_pulse_a: assert property ($rose(wdt_force) |=>
        !watchdog_output_pin_o)
        else $error("watchdog pin not pulled low");
    slow_irq_a: assert property (slow_mode |->
        !periodic_irq_en_o)
        else $error("periodic interrupt left on in slow mode");
    rtc_full_a: assert property (slow_tick |-> rtc_tick_o)
        else $error("timer tick missing on 32 kHz edge");
endmodule : ccps_top
`default_nettype wire

// *** verif/ccps_tb_top.sv ***
// Self-checking bench for the clock select and power save block.
// Assumes ccps_pkg; a 24-cycle wave stands in for the 32 kHz pin.
`timescale 1ns/1ps
`default_nettype none
module ccps_tb_top;
    import ccps_pkg::*;
    logic            clk_i = 0, rst_i = 1, clk32_i = 0, quiet = 0;
    logic            watchdog_n_i = 1, pw, q;
    logic [3:0]      c32 = 0;
    ccps_wb_req_type wb_req_i = '0;
    ccps_cycle_type  cycle_i = '0, pc;
    logic [31:0]     wb_dat_o, rd;
    logic [8:0]      self_timed_ns_o;
    logic [4:0]      doubler_low_ns_o;
    logic            wb_ack_o, cpu_tick_o, per_tick_o, rtc_tick_o;
    logic            main_osc_en_o, spread_en_o, spread_strong_o;
    logic            doubler_en_o, short_cs_o, short_cs_write_o;
    logic            periodic_irq_en_o, clk_pin_o, status_pin_o;
    logic            watchdog_output_pin_o, buffer_enable_n_o;
    integer          seed = 8278, mismatches = 0, checked = 0;
    int              n, m, k, r, c, t;
    logic [2:0]      cs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    int              dv8 [8] = '{8, 8, 1, 2, 1, 1, 4, 6};
    int              dvs [8] = '{1, 1, 1, 1, 2, 4, 8, 16};
    logic [8:0]      stn [8] = '{9'h0, 9'h0, 9'h0, 9'h0, STC_NS_100,
                                 STC_NS_101, STC_NS_110, STC_NS_111};

    ccps_top dut (.*);

    ////////////////////////////////////////////////////////////////////////
    // Clock, random pin sources and the slow oscillator stand-in
    always #20 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        pc           <= cycle_i;
        pw           <= watchdog_n_i;
        cycle_i      <= 4'($random(seed));
        watchdog_n_i <= quiet | 1'($random(seed));
        c32          <= (c32 == 4'hB) ? 4'h0 : c32 + 4'h1;
        if (c32 == 4'hB)
            clk32_i <= ~clk32_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, report and finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic close_out;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // One classic Wishbone cycle on byte lane 0, read data into rd
    task automatic wb(input logic w, input logic [5:0] i,
                      input logic [7:0] d);
        @(posedge clk_i);
        wb_req_i <= '{1'b1, 1'b1, w, 4'h1, {i, 2'h0}, {24'h0, d}};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1)
        begin
            mismatches++;
            close_out();
        end
        rd = wb_dat_o;
        wb_req_i <= '0;
    endtask : wb

    // Tick counts over a window
    task automatic cnt(input int len);
        k = 0;
        m = 0;
        r = 0;
        repeat (len)
        begin
            @(posedge clk_i);
            k += cpu_tick_o;
            m += per_tick_o;
            r += rtc_tick_o;
        end
    endtask : cnt

    // Slow ticks between two processor ticks, into k
    task automatic gap;
        k = 0;
        for (m = 0; m < 900 && cpu_tick_o !== 1'b1; m++)
            @(posedge clk_i);
        do
        begin
            @(posedge clk_i);
            k += rtc_tick_o;
            m++;
        end
        while (cpu_tick_o !== 1'b1 && m < 1800);
        if (m >= 1800)
        begin
            mismatches++;
            close_out();
        end
    endtask : gap

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        cnt(48);
        chk(k, 6);
        wb(1, IDX_PSC, 8'h18);
        foreach (cs[i])
        begin
            wb(1, IDX_GCS, {3'h0, cs[i], 2'h0});
            repeat (8) @(posedge clk_i);
            cnt(48);
            chk(k, 48 / dv8[cs[i]]);
            chk(m, (cs[i] == 3'h1) ? 48 : 48 / dv8[cs[i]]);
            chk(short_cs_o, cs[i] != 3'h2);
            chk(short_cs_write_o, cs[i] != 3'h2);
            chk(main_osc_en_o, 1);
        end
        for (c = 0; c < 8; c++)
        begin
            if (c == 0 || c > 3)
            begin
                wb(1, IDX_GCS, {3'h0, 2'h2, c[0], 2'h0});
                wb(1, IDX_PSC, {c[2:0], 2'h0, c[2:0]});
                gap();
                gap();
                chk(k, dvs[c]);
                cnt(96);
                chk(r, 4);
                chk(self_timed_ns_o, stn[c]);
                chk(main_osc_en_o, !c[0]);
                chk(periodic_irq_en_o, 0);
            end
        end
        wb(1, IDX_GCS, 8'h08);
        @(posedge clk_i);
        chk(periodic_irq_en_o, 1);
        for (c = 0; c < 2; c++)
        begin
            wb(1, IDX_SPRD_STR, {c[0], 7'h0});
            wb(1, IDX_SPRD_EN, {!c[0], 7'h0});
            wb(0, IDX_SPRD_STR, 8'h0);
            chk(rd, {c[0], 7'h0});
            chk(spread_strong_o, c[0]);
            chk(spread_en_o, !c[0]);
        end
        for (c = 0; c < 16; c++)
        begin
            wb(1, IDX_DBL, {4'h0, c[3:0]});
            @(posedge clk_i);
            chk(doubler_en_o, c != 0);
            chk(doubler_low_ns_o, (c != 0) ? c + 5 : 0);
        end
        for (c = 0; c < 4; c++)
        begin
            wb(1, IDX_OPC, {c[1:0], c[1:0], 2'h1, c[1:0]});
            repeat (2) @(posedge clk_i);
            t = 0;
            q = clk_pin_o;
            repeat (16)
            begin
                @(posedge clk_i);
                chk(status_pin_o, c[1] ? c[0] :
                    !(c[0] ? pc.int_ack : pc.opcode_fetch));
                chk(buffer_enable_n_o, c[1] ? c[0] :
                    !(c[0] ? pc.data_mem : pc.ext_io));
                chk(watchdog_output_pin_o, pw);
                t += (clk_pin_o !== q);
                q = clk_pin_o;
                if (c > 1)
                    chk(clk_pin_o, c[0]);
            end
            if (c < 2)
                chk(t, c ? 8 : 16);
        end
        quiet <= 1'b1;
        wb(1, IDX_OPC, 8'h08);
        k = 0;
        repeat (120)
        begin
            @(posedge clk_i);
            k += !watchdog_output_pin_o;
        end
        chk(k >= 22 && k <= 56, 1);
        chk(watchdog_output_pin_o, 1);
        wb(0, IDX_OPC, 8'h0);
        chk(rd, 0);
        wb(0, IDX_STATE, 8'h0);
        chk(rd, 8'h07);
        wb(0, IDX_GCS, 8'h0);
        chk(rd, 8'h08);
        wb(0, 6'h3F, 8'h0);
        chk(rd, 0);
        close_out();
    end
endmodule : ccps_tb_top
`default_nettype wire
